// ===== admr_bank.sv
// Mode register bank with gated, ramped per-channel attenuation.
// Summary of operation
// - Command bit 15 set reads a register, clear writes it.
// - Zero-flag and identifier registers are read-only; writes change nothing.
// - Bits 14..8 hold the register index, bits 7..0 the data.
// - Each channel has its own 8-bit code, reset to all ones.
// - Codes 15 to 255 give half-dB gain steps, code minus 255.
// - Codes 0 to 14 fully mute the channel.
// - One load enable bit gates both channel attenuators together.
// - Load enable low holds the old levels; it resets low.
// - Three-bit format field picks audio input format, reset 24-bit I2S.
// - In filter bypass mode the format field is passed raw instead.
// - Two-bit rate field picks de-emphasis frequency, reset disabled.
// - De-emphasis acts on both channels only while enabled; resets off.
// - In one-bit stream mode the rate field selects FIR performance.
// - Soft mute bit mutes both channels; reset unmuted.
// - Soft mute ramps down step by step at the selected rate.
// - Step rate field moves one step every 1, 2, 4 or 8 frames.
`timescale 1ns/100ps
module admr_bank #(
	parameter logic [4:0] DEVICE_ID = 5'h0a // Value is arbitrary.
) (
	input wire logic ref_clk, // System clock.
	input wire logic sys_rst, // Synchronous reset, active high.
	input wire logic cmd_valid, // One-cycle strobe of a command word.
	input wire logic [15:0] cmd_word, // Command word.
	output logic rd_valid, // Read answer strobe.
	output logic [7:0] rd_data, // Read answer data.
	input wire logic frame_clock, // Frame clock, sampled.
	input wire logic left_zero_flag, // Left zero detect from datapath.
	input wire logic right_zero_flag, // Right zero detect from datapath.
	output logic [7:0] left_level, // Applied left code.
	output logic [7:0] right_level, // Applied right code.
	output logic left_muted, // Left applied code in mute range.
	output logic right_muted, // Right applied code in mute range.
	output logic soft_system_reset, // One-cycle soft reset pulse.
	output admr_pkg::admr_cfg_t cfg // Decoded mode settings.
);
	logic [7:0] left_gain_code_reg, left_gain_code_next;
	logic [7:0] right_gain_code_reg, right_gain_code_next;
	logic [7:0] ctrl_reg, ctrl_next;
	logic [7:0] filt_reg, filt_next;
	logic [7:0] sys_reg, sys_next;
	logic [7:0] zen_reg, zen_next;
	logic rd_valid_reg, rd_valid_next;
	logic [7:0] rd_data_reg, rd_data_next;
	logic soft_system_reset_reg, soft_system_reset_next;
	logic frame_prev_reg, frame_prev_next;
	logic [2:0] div_reg, div_next;
	logic [2:0] div_limit;
	logic step;
	logic [6:0] idx;
	logic wr_en;
	logic [7:0] wdat;
	logic gain_load_enable;
	logic [7:0] code_in [2];
	logic [7:0] level [2];
	logic [7:0] target [2];

	assign idx = cmd_word[admr_pkg::CMD_IDX_HI:admr_pkg::CMD_IDX_LO];
	assign wdat = cmd_word[7:0];
	assign wr_en = cmd_valid && !cmd_word[admr_pkg::CMD_RW_BIT];
	assign gain_load_enable = ctrl_reg[admr_pkg::LOAD_BIT];

	always_comb begin
		left_gain_code_next = left_gain_code_reg;
		right_gain_code_next = right_gain_code_reg;
		ctrl_next = ctrl_reg;
		filt_next = filt_reg;
		sys_next = sys_reg;
		zen_next = zen_reg;
		soft_system_reset_next = 1'b0;
		rd_valid_next = 1'b0;
		rd_data_next = rd_data_reg;
		if (wr_en) begin
			// Indices 22, 23 and unmapped ones fall through untouched.
			unique case (idx)
				admr_pkg::IDX_LEFT: left_gain_code_next = wdat;
				admr_pkg::IDX_RIGHT: right_gain_code_next = wdat;
				admr_pkg::IDX_CTRL: ctrl_next = wdat;
				admr_pkg::IDX_FILT: filt_next = wdat & admr_pkg::FILT_MASK;
				admr_pkg::IDX_SYS: begin
					sys_next = wdat & admr_pkg::SYS_MASK;
					soft_system_reset_next = wdat[admr_pkg::SOFT_RST_BIT];
				end
				admr_pkg::IDX_ZEN: zen_next = wdat & admr_pkg::ZEN_MASK;
				default: ;
			endcase
		end
		if (cmd_valid && cmd_word[admr_pkg::CMD_RW_BIT]) begin
			rd_valid_next = 1'b1;
			unique case (idx)
				admr_pkg::IDX_LEFT: rd_data_next = left_gain_code_reg;
				admr_pkg::IDX_RIGHT: rd_data_next = right_gain_code_reg;
				admr_pkg::IDX_CTRL: rd_data_next = ctrl_reg;
				admr_pkg::IDX_FILT: rd_data_next = filt_reg;
				// The soft reset bit is write-only and reads back as zero.
				admr_pkg::IDX_SYS: rd_data_next = sys_reg;
				admr_pkg::IDX_ZEN: rd_data_next = zen_reg;
				admr_pkg::IDX_ZST: rd_data_next = {6'h00, right_zero_flag,
					left_zero_flag};
				admr_pkg::IDX_ID: rd_data_next = {3'h0, DEVICE_ID};
				default: rd_data_next = 8'h00;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			left_gain_code_reg <= admr_pkg::LEVEL_RST;
			right_gain_code_reg <= admr_pkg::LEVEL_RST;
			ctrl_reg <= admr_pkg::CTRL_RST;
			filt_reg <= admr_pkg::FILT_RST;
			sys_reg <= admr_pkg::SYS_RST_VAL;
			zen_reg <= admr_pkg::ZEN_RST;
			soft_system_reset_reg <= 1'b0;
			rd_valid_reg <= 1'b0;
			rd_data_reg <= 8'h00;
		end else begin
			left_gain_code_reg <= left_gain_code_next;
			right_gain_code_reg <= right_gain_code_next;
			ctrl_reg <= ctrl_next;
			filt_reg <= filt_next;
			sys_reg <= sys_next;
			zen_reg <= zen_next;
			soft_system_reset_reg <= soft_system_reset_next;
			rd_valid_reg <= rd_valid_next;
			rd_data_reg <= rd_data_next;
		end
	end

	assign rd_valid = rd_valid_reg;
	assign rd_data = rd_data_reg;
	assign soft_system_reset = soft_system_reset_reg;

	// Step pacing: one step per 1, 2, 4 or 8 frame clock rising edges.
	assign div_limit =
		3'((4'h1 << filt_reg[admr_pkg::STEP_RATE_LO +: 2]) - 4'h1);
	assign step = frame_clock && !frame_prev_reg &&
		(div_reg >= div_limit);

	always_comb begin
		frame_prev_next = frame_clock;
		div_next = div_reg;
		if (frame_clock && !frame_prev_reg) begin
			div_next = (div_reg >= div_limit) ? 3'h0 : 3'(div_reg + 3'h1);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			frame_prev_reg <= 1'b0;
			div_reg <= 3'h0;
		end else begin
			frame_prev_reg <= frame_prev_next;
			div_reg <= div_next;
		end
	end

	assign code_in[0] = left_gain_code_reg;
	assign code_in[1] = right_gain_code_reg;

	for (genvar ch = 0; ch < 2; ch++) begin : g_chan
		logic [7:0] target_reg, target_next;
		logic [7:0] level_reg, level_next;
		logic [7:0] goal;
		always_comb begin
			// Codes are only taken while loading is enabled.
			target_next = gain_load_enable ? code_in[ch] : target_reg;
			// Soft mute ramps to the mute code through every step.
			goal = ctrl_reg[admr_pkg::MUTE_BIT] ? admr_pkg::MUTE_CODE : target_reg;
			level_next = level_reg;
			if (step && level_reg < goal) begin
				level_next = 8'(level_reg + 8'h01);
			end else if (step && level_reg > goal) begin
				level_next = 8'(level_reg - 8'h01);
			end
		end
		always_ff @(posedge ref_clk) begin
			if (sys_rst) begin
				target_reg <= admr_pkg::LEVEL_RST;
				level_reg <= admr_pkg::LEVEL_RST;
			end else begin
				target_reg <= target_next;
				level_reg <= level_next;
			end
		end
		assign level[ch] = level_reg;
		assign target[ch] = target_reg;
	end

	assign left_level = level[0];
	assign right_level = level[1];
	assign left_muted = level[0] < admr_pkg::MUTE_FLOOR;
	assign right_muted = level[1] < admr_pkg::MUTE_FLOOR;

	always_comb begin
		cfg.phase_invert = filt_reg[admr_pkg::INVERT_BIT];
		cfg.gain_step_rate = filt_reg[admr_pkg::STEP_RATE_LO +: 2];
		cfg.output_disable = filt_reg[admr_pkg::OUT_DIS_BIT];
		cfg.bypass_stereo_sel = filt_reg[admr_pkg::BYP_STEREO_BIT];
		cfg.rolloff_sel = filt_reg[admr_pkg::ROLLOFF_BIT];
		cfg.zero_detect_silence = filt_reg[admr_pkg::SILENCE_BIT];
		cfg.one_bit_stream_mode = sys_reg[admr_pkg::STREAM_BIT];
		cfg.filter_bypass = sys_reg[admr_pkg::BYPASS_BIT];
		cfg.mono = sys_reg[admr_pkg::MONO_BIT];
		cfg.single_channel_source = sys_reg[admr_pkg::CHAN_SRC_BIT];
		cfg.modulator_rate_sel = sys_reg[admr_pkg::MOD_RATE_LO +: 2];
		cfg.stream_zero_pattern_sel = zen_reg[admr_pkg::ZPAT_LO +: 2];
		cfg.pulse_code_zero_flag_enable = zen_reg[admr_pkg::PCZ_EN_BIT];
		cfg.audio_format_sel =
			admr_pkg::admr_fmt_t'(ctrl_reg[admr_pkg::FORMAT_LO +: 3]);
		// Reserved codes and bypass mode both leave the table unused.
		cfg.audio_format_valid = !cfg.filter_bypass &&
			(!ctrl_reg[admr_pkg::FORMAT_LO + 2] |
			!ctrl_reg[admr_pkg::FORMAT_LO + 1]);
		cfg.bypass_format = cfg.filter_bypass ?
			ctrl_reg[admr_pkg::FORMAT_LO +: 3] : 3'h0;
		// In one-bit stream mode the rate field drives the FIR instead.
		cfg.deemph_active = ctrl_reg[admr_pkg::DEEMPH_BIT] &&
			!cfg.one_bit_stream_mode;
		cfg.deemph_rate_sel = cfg.one_bit_stream_mode ?
			2'h0 : ctrl_reg[admr_pkg::DERATE_LO +: 2];
		cfg.fir_perf_sel = cfg.one_bit_stream_mode ?
			ctrl_reg[admr_pkg::DERATE_LO +: 2] : 2'h0;
		cfg.soft_mute = ctrl_reg[admr_pkg::MUTE_BIT];
	end

	property p_rd_answer;
		@(posedge ref_clk) disable iff (sys_rst)
		cmd_valid && cmd_word[15] |=> rd_valid;
	endproperty
	a_rd_answer: assert property (p_rd_answer)
		else $error("read not answered");

	property p_wr_silent;
		@(posedge ref_clk) disable iff (sys_rst)
		cmd_valid && !cmd_word[15] |=> !rd_valid;
	endproperty
	a_wr_silent: assert property (p_wr_silent)
		else $error("write answered");

	property p_ro_write;
		@(posedge ref_clk) disable iff (sys_rst)
		cmd_valid && !cmd_word[15] && cmd_word[14:9] == 6'h0b |=>
			$stable(ctrl_reg) && $stable(zen_reg) && $stable(left_gain_code_reg);
	endproperty
	a_ro_write: assert property (p_ro_write)
		else $error("read-only write");

	property p_idx_write;
		@(posedge ref_clk) disable iff (sys_rst)
		cmd_valid && cmd_word[15:8] == 8'h11 |=>
			right_gain_code_reg == $past(cmd_word[7:0]);
	endproperty
	a_idx_write: assert property (p_idx_write)
		else $error("index write lost");

	property p_reset_vals;
		@(posedge ref_clk)
		sys_rst |=> left_level == admr_pkg::LEVEL_RST &&
			ctrl_reg == admr_pkg::CTRL_RST && zen_reg == admr_pkg::ZEN_RST;
	endproperty
	a_reset_vals: assert property (p_reset_vals)
		else $error("bad reset value");

	property p_hold;
		@(posedge ref_clk) disable iff (sys_rst)
		!gain_load_enable |=> $stable(target[0]) && $stable(target[1]);
	endproperty
	a_hold: assert property (p_hold)
		else $error("target moved unloaded");

	property p_load_take;
		@(posedge ref_clk) disable iff (sys_rst)
		gain_load_enable |=> target[0] == $past(left_gain_code_reg) &&
			target[1] == $past(right_gain_code_reg);
	endproperty
	a_load_take: assert property (p_load_take)
		else $error("load enable ignored");

	// The rate may change under way, so only slowest-rate steps are timed.
	property p_step_gap;
		@(posedge ref_clk) disable iff (sys_rst)
		step && cfg.gain_step_rate == 2'h3 |=>
			(!step || cfg.gain_step_rate != 2'h3) [*8];
	endproperty
	a_step_gap: assert property (p_step_gap)
		else $error("step came too soon");

	property p_one_step;
		@(posedge ref_clk) disable iff (sys_rst)
		!step |=> $stable(level[0]) && $stable(level[1]);
	endproperty
	a_one_step: assert property (p_one_step)
		else $error("level moved off step");

	property p_mute_ramp;
		@(posedge ref_clk) disable iff (sys_rst)
		cfg.soft_mute && step && level[0] != 8'h00 |=>
			level[0] == 8'($past(level[0]) - 8'h01);
	endproperty
	a_mute_ramp: assert property (p_mute_ramp)
		else $error("mute ramp wrong");

	property p_soft_system_reset_pulse;
		@(posedge ref_clk) disable iff (sys_rst)
		cmd_valid && cmd_word[15:8] == 8'h14 && cmd_word[6] |=>
			soft_system_reset ##1 !soft_system_reset;
	endproperty
	a_soft_system_reset_pulse: assert property (p_soft_system_reset_pulse)
		else $error("bad reset pulse");

	c_read: cover property (@(posedge ref_clk) disable iff (sys_rst)
		rd_valid && rd_data != 8'h00);
	c_muted: cover property (@(posedge ref_clk) disable iff (sys_rst)
		cfg.soft_mute && left_level == 8'h00);
	c_ramp_up: cover property (@(posedge ref_clk) disable iff (sys_rst)
		step && level[1] < target[1]);
	c_slow_step: cover property (@(posedge ref_clk) disable iff (sys_rst)
		step && cfg.gain_step_rate == 2'h3);
	c_soft_reset: cover property (@(posedge ref_clk) disable iff (sys_rst)
		soft_system_reset);
endmodule

// ===== admr_host.sv
// Host model that issues command words on the register port.
`timescale 1ns/100ps
module admr_host (
	input wire logic ref_clk, // System clock.
	output logic cmd_valid, // Command strobe.
	output logic [15:0] cmd_word, // Command word.
	input wire logic rd_valid, // Read answer strobe.
	input wire logic [7:0] rd_data // Read answer data.
);
	initial begin
		cmd_valid = 1'b0;
		cmd_word = 16'h0000;
	end
	task automatic send(input logic r, input logic [6:0] idx,
		input logic [7:0] d);
		@(posedge ref_clk);
		#1;
		cmd_valid = 1'b1;
		cmd_word = {r, idx, d};
		@(posedge ref_clk);
		#1;
		cmd_valid = 1'b0;
		// A released word shows its inverse so stale data never passes.
		cmd_word = ~cmd_word;
	endtask
	task automatic wr(input logic [6:0] idx, input logic [7:0] d);
		send(1'b0, idx, d);
	endtask
	task automatic rd(input logic [6:0] idx, output logic [7:0] d,
		output logic ok);
		send(1'b1, idx, 8'h00);
		ok = 1'b0;
		d = 8'h00;
		repeat (3) begin
			if (!ok && rd_valid === 1'b1) begin
				ok = 1'b1;
				d = rd_data;
			end else if (!ok) begin
				@(posedge ref_clk);
				#1;
			end
		end
	endtask
endmodule

// ===== admr_pkg.sv
// Constants, field layout and carrier types for the audio mode register bank.
package admr_pkg;
	localparam int CMD_RW_BIT = 15;
	localparam int CMD_IDX_HI = 14;
	localparam int CMD_IDX_LO = 8;
	localparam logic [6:0] IDX_LEFT = 7'h10;
	localparam logic [6:0] IDX_RIGHT = 7'h11;
	localparam logic [6:0] IDX_CTRL = 7'h12;
	localparam logic [6:0] IDX_FILT = 7'h13;
	localparam logic [6:0] IDX_SYS = 7'h14;
	localparam logic [6:0] IDX_ZEN = 7'h15;
	localparam logic [6:0] IDX_ZST = 7'h16;
	localparam logic [6:0] IDX_ID = 7'h17;
	localparam logic [7:0] LEVEL_RST = 8'hff;
	localparam logic [7:0] CTRL_RST = 8'h50;
	localparam logic [7:0] FILT_RST = 8'h00;
	localparam logic [7:0] SYS_RST_VAL = 8'h00;
	localparam logic [7:0] ZEN_RST = 8'h01;
	localparam logic [7:0] FILT_MASK = 8'hf7;
	localparam logic [7:0] SYS_MASK = 8'h3f;
	localparam logic [7:0] ZEN_MASK = 8'h07;
	localparam int LOAD_BIT = 7;
	localparam int FORMAT_LO = 4;
	localparam int DERATE_LO = 2;
	localparam int DEEMPH_BIT = 1;
	localparam int MUTE_BIT = 0;
	localparam int INVERT_BIT = 7;
	localparam int STEP_RATE_LO = 5;
	localparam int OUT_DIS_BIT = 4;
	localparam int BYP_STEREO_BIT = 2;
	localparam int ROLLOFF_BIT = 1;
	localparam int SILENCE_BIT = 0;
	localparam int SOFT_RST_BIT = 6;
	localparam int STREAM_BIT = 5;
	localparam int BYPASS_BIT = 4;
	localparam int MONO_BIT = 3;
	localparam int CHAN_SRC_BIT = 2;
	localparam int MOD_RATE_LO = 0;
	localparam int ZPAT_LO = 1;
	localparam int PCZ_EN_BIT = 0;
	localparam logic [7:0] MUTE_FLOOR = 8'h0f;
	localparam logic [7:0] FULL_SCALE = 8'hff;
	localparam logic [7:0] MUTE_CODE = 8'h00;

	typedef enum logic [2:0] {
		AF_RJ16 = 3'b000,
		AF_RJ20 = 3'b001,
		AF_RJ24 = 3'b010,
		AF_LJ24 = 3'b011,
		AF_I2S16 = 3'b100,
		AF_I2S24 = 3'b101,
		AF_RES6 = 3'b110,
		AF_RES7 = 3'b111
	} admr_fmt_t;

	typedef struct packed {
		logic phase_invert;
		logic [1:0] gain_step_rate;
		logic output_disable;
		logic bypass_stereo_sel;
		logic rolloff_sel;
		logic zero_detect_silence;
		logic one_bit_stream_mode;
		logic filter_bypass;
		logic mono;
		logic single_channel_source;
		logic [1:0] modulator_rate_sel;
		logic [1:0] stream_zero_pattern_sel;
		logic pulse_code_zero_flag_enable;
		admr_fmt_t audio_format_sel;
		logic audio_format_valid;
		logic [2:0] bypass_format;
		logic deemph_active;
		logic [1:0] deemph_rate_sel;
		logic [1:0] fir_perf_sel;
		logic soft_mute;
	} admr_cfg_t;
endpackage

// ===== audio_dac_mode_registers_tb.sv
// Self-checking bench for the audio mode register bank.
`timescale 1ns/100ps
module audio_dac_mode_registers_tb;
	localparam logic [4:0] ID_VAL = 5'h15; // Value is arbitrary.
	logic ref_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic frame_clock = 1'b0;
	logic lzf = 1'b0;
	logic rzf = 1'b0;
	logic cmd_valid;
	logic rd_valid;
	logic left_muted;
	logic right_muted;
	logic soft_system_reset;
	logic ok;
	logic [15:0] cmd_word;
	logic [7:0] rd_data;
	logic [7:0] left_level;
	logic [7:0] right_level;
	logic [7:0] d;
	logic [7:0] m;
	logic [6:0] idx;
	logic [31:0] seed = 32'h80a1b4d1;
	admr_pkg::admr_cfg_t cfg;
	int failures = 0;
	int samples_checked = 0;
	always #4 ref_clk = ~ref_clk;
	admr_bank #(.DEVICE_ID(ID_VAL)) dut_u (.ref_clk(ref_clk),
		.sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd_word(cmd_word),
		.rd_valid(rd_valid), .rd_data(rd_data), .frame_clock(frame_clock),
		.left_zero_flag(lzf), .right_zero_flag(rzf),
		.left_level(left_level), .right_level(right_level),
		.left_muted(left_muted), .right_muted(right_muted),
		.soft_system_reset(soft_system_reset), .cfg(cfg));
	admr_host host_u (.ref_clk(ref_clk), .cmd_valid(cmd_valid),
		.cmd_word(cmd_word), .rd_valid(rd_valid), .rd_data(rd_data));
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction
	function automatic logic [7:0] wmask(input logic [6:0] i);
		return i == 7'h13 ? 8'hf7 : i == 7'h14 ? 8'h3f :
			i == 7'h15 ? 8'h07 : 8'hff;
	endfunction
	task automatic conclude();
		if (failures == 0 && samples_checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t byte %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk1(input logic got, input logic exp);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t bit %b expected %b", $time, got, exp);
		end
	endtask
	task automatic rdchk(input logic [6:0] i, input logic [7:0] exp);
		host_u.rd(i, d, ok);
		chk1(ok, 1'b1);
		chk8(d, exp);
	endtask
	task automatic frames(input int n);
		repeat (n) begin
			@(posedge ref_clk);
			#1;
			frame_clock = 1'b1;
			repeat (2) @(posedge ref_clk);
			#1;
			frame_clock = 1'b0;
			@(posedge ref_clk);
		end
		@(posedge ref_clk);
		#1;
	endtask
	task automatic do_reset();
		@(posedge ref_clk);
		#1;
		sys_rst = 1'b1;
		repeat (10) @(posedge ref_clk);
		#1;
		sys_rst = 1'b0;
	endtask
	initial begin
		#200000;
		failures++;
		conclude();
	end
	initial begin
		do_reset();
		seed = xs(seed);
		lzf = seed[0];
		rzf = seed[1];
		rdchk(7'h10, 8'hff);
		rdchk(7'h11, 8'hff);
		rdchk(7'h12, 8'h50);
		rdchk(7'h13, 8'h00);
		rdchk(7'h15, 8'h01);
		rdchk(7'h16, {6'h00, rzf, lzf});
		rdchk(7'h17, {3'h0, ID_VAL});
		rdchk(7'h20, 8'h00);
		host_u.wr(7'h16, 8'hff);
		host_u.wr(7'h17, 8'h00);
		rdchk(7'h16, {6'h00, rzf, lzf});
		rdchk(7'h17, {3'h0, ID_VAL});
		host_u.wr(7'h10, 8'h80);
		frames(3);
		chk8(left_level, 8'hff);
		host_u.wr(7'h12, 8'hd0);
		frames(3);
		chk8(left_level, 8'hfc);
		chk8(right_level, 8'hff);
		host_u.wr(7'h13, 8'h60);
		frames(16);
		chk8(left_level, 8'hfa);
		host_u.wr(7'h13, 8'h00);
		host_u.wr(7'h10, 8'h0e);
		host_u.wr(7'h11, 8'h0f);
		frames(260);
		chk8(left_level, 8'h0e);
		chk8(right_level, 8'h0f);
		chk1(left_muted, 1'b1);
		chk1(right_muted, 1'b0);
		host_u.wr(7'h12, 8'hd1);
		frames(20);
		chk8(left_level, 8'h00);
		chk8(right_level, 8'h00);
		host_u.wr(7'h12, 8'hd0);
		frames(20);
		chk8(right_level, 8'h0f);
		host_u.wr(7'h12, 8'h50);
		host_u.wr(7'h10, 8'h40);
		frames(3);
		chk8(left_level, 8'h0e);
		repeat (12) begin
			seed = xs(seed);
			idx = 7'h10 + 7'(seed[10:8] % 3'h6);
			m = wmask(idx);
			host_u.wr(idx, seed[7:0]);
			rdchk(idx, seed[7:0] & m);
		end
		do_reset();
		rdchk(7'h10, 8'hff);
		for (int f = 0; f < 8; f++) begin
			host_u.wr(7'h12, {1'b0, 3'(f), 4'h6});
			chk8(8'(cfg.audio_format_sel), 8'(f));
			chk1(cfg.audio_format_valid, f < 6);
			chk1(cfg.deemph_active, 1'b1);
			chk8(8'(cfg.deemph_rate_sel), 8'h01);
		end
		host_u.wr(7'h14, 8'h20);
		chk1(cfg.deemph_active, 1'b0);
		chk8(8'(cfg.fir_perf_sel), 8'h01);
		host_u.wr(7'h14, 8'h10);
		chk1(cfg.audio_format_valid, 1'b0);
		chk8(8'(cfg.bypass_format), 8'h07);
		host_u.wr(7'h13, 8'hb5);
		m = {cfg.phase_invert, cfg.gain_step_rate, cfg.output_disable, 1'b0,
			cfg.bypass_stereo_sel, cfg.rolloff_sel, cfg.zero_detect_silence};
		chk8(m, 8'hb5);
		host_u.wr(7'h14, 8'h0e);
		host_u.wr(7'h15, 8'h05);
		m = {1'b0, cfg.mono, cfg.single_channel_source, cfg.modulator_rate_sel,
			cfg.stream_zero_pattern_sel, cfg.pulse_code_zero_flag_enable};
		chk8(m, 8'h75);
		host_u.wr(7'h14, 8'h40);
		chk1(soft_system_reset, 1'b1);
		@(posedge ref_clk);
		#1;
		chk1(soft_system_reset, 1'b0);
		conclude();
	end
endmodule
